// ===== logic/srwd_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SRWD_CONSTS_SVH
`define SRWD_CONSTS_SVH
`define SRWD_IDX_WAKE 8'h0B
`define SRWD_IDX_WDM 8'h0F
`define SRWD_ADDR_WAKE 12'h02C
`define SRWD_ADDR_WDM 12'h03C
`define SRWD_ADDR_CTRL 12'h040
`define SRWD_ADDR_STAT 12'h044
`define SRWD_WAKE_RST 8'h20
`define SRWD_WDM_RST 8'h0D
`define SRWD_WAKE_MASK 8'h7C
`define SRWD_WDM_MASK 8'h1F
`define SRWD_SRC_LO 2
`define SRWD_DLY_BIT 5
`define SRWD_POL_BIT 6
`define SRWD_HALT_BIT 2
`define SRWD_STOP_BIT 3
`define SRWD_CSRC_BIT 4
`define SRWD_WIN_CYC 64
`define SRWD_POR_MS 5
`define SRWD_CLK_KHZ 25000
`define SRWD_RC_KHZ 25000
`define SRWD_TAP0_MS 5
`define SRWD_TAP1_MS 15
`define SRWD_TAP2_MS 25
`define SRWD_TAP3_MS 100
`define SRWD_XT0 256
`define SRWD_XT1 512
`define SRWD_XT2 1024
`define SRWD_XT3 4096
`define SRWD_RESTART 16'h000C
`endif

// ===== logic/srwd_pkg.sv
// Types shared by the recovery and watchdog block
package srwd_pkg;
  typedef enum logic [1:0] {
    SRWD_RUN,
    SRWD_HALT,
    SRWD_STOP
  } srwd_mode_t;
endpackage

// ===== logic/srwd_sync3.sv
// Three-stage synchroniser with agreement filter for a pin bus
`timescale 1ns/1ns
module srwd_sync3 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  // A bit moves only once the two later stages agree
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign pin_out = q_ff;
endmodule

// ===== logic/srwd_top.sv
// Stop-mode recovery and watchdog control with an APB register port
//
// What this block does
// - Three-bit field picks the wake source
// - Port 2 outputs read high for NOR
// - Delay bit set skips reset delay; default one
// - Polarity bit picks wake level; clears on power-up
// - Read-only flag: zero cold, one warm
// - Watchdog one-shot resets core at terminal count
// - First refresh starts watchdog; later ones restart
// - Refresh changes zero, sign, overflow flags
// - Mode register writable only first 64 cycles
// - Mode register write-only, reads return zero
// - Two-bit tap picks timeout; default 15 ms
// - Halt bit keeps watchdog counting in halt
// - Stop bit keeps counting in stop on RC
// - Clock-source bit picks crystal or RC ticks
// - Mode bits five to seven reserved
// - Low supply holds global reset
// - Power-on delay triggered by power, wake, timeout
// - Wake register: write-only bits, bit seven read
// - Leaving stop restarts at address 000CH
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "srwd_consts.svh"
module srwd_top #(
  parameter int POR_CYC = `SRWD_POR_MS * `SRWD_CLK_KHZ,
  parameter int RC_MS_CYC = `SRWD_RC_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] port3_in,
  input wire logic [7:0] port2_in,
  input wire logic [7:0] port2_is_output,
  input wire logic low_voltage_trip_level,
  input wire logic crystal_clock_tick,
  input wire logic rc_clock_tick,
  input wire logic refresh_cmd,
  input wire logic halt_cmd,
  input wire logic stop_cmd,
  output logic global_reset,
  output logic wake_restart,
  output logic [15:0] restart_addr,
  output logic [2:0] flag_update,
  output logic wd_running
);
  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [3:0] p3_s;
  logic [7:0] p2_s;
  logic [1:0] tk_s;

  srwd_sync3 #(.W(4)) u_p3 (
    .clk(clk), .rst(rst), .pin_in(port3_in), .pin_out(p3_s)
  );
  srwd_sync3 #(.W(8)) u_p2 (
    .clk(clk), .rst(rst), .pin_in(port2_in), .pin_out(p2_s)
  );
  // Supply comparator is asynchronous, so it is filtered like a pin
  logic lv_s;
  srwd_sync3 #(.W(1)) u_lv (
    .clk(clk), .rst(rst), .pin_in(low_voltage_trip_level), .pin_out(lv_s)
  );
  srwd_sync3 #(.W(2)) u_tk (
    .clk(clk), .rst(rst),
    .pin_in({crystal_clock_tick, rc_clock_tick}), .pin_out(tk_s)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] wake_ff, nxt_wake;
  logic [7:0] wdm_ff, nxt_wdm;
  logic warm_ff, nxt_warm;
  logic [6:0] win_ff, nxt_win;
  logic [31:0] por_ff, nxt_por;
  logic [31:0] wd_ff, nxt_wd;
  logic wd_on_ff, nxt_wd_on;
  srwd_pkg::srwd_mode_t mode_ff, nxt_mode;
  logic [1:0] tk_d_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic grst_ff, nxt_grst;
  logic wrst_ff, nxt_wrst;
  logic [2:0] flag_ff, nxt_flag;

  // Timeout length in ticks for a tap code and clock choice
  function automatic logic [31:0] tap_len(input logic [1:0] tap,
                                          input logic xtal);
    logic [31:0] r;
    r = '0;
    if (xtal) begin
      case (tap)
        2'h0: r = 32'(`SRWD_XT0);
        2'h1: r = 32'(`SRWD_XT1);
        2'h2: r = 32'(`SRWD_XT2);
        default: r = 32'(`SRWD_XT3);
      endcase
    end else begin
      case (tap)
        2'h0: r = 32'(`SRWD_TAP0_MS * RC_MS_CYC);
        2'h1: r = 32'(`SRWD_TAP1_MS * RC_MS_CYC);
        2'h2: r = 32'(`SRWD_TAP2_MS * RC_MS_CYC);
        default: r = 32'(`SRWD_TAP3_MS * RC_MS_CYC);
      endcase
    end
    return r;
  endfunction

  // ****************************************************************
  // Wake source selection
  // ****************************************************************
  logic [7:0] p2_eff;
  logic src_lvl, wake_hit;
  logic [2:0] src_sel;
  always_comb begin
    // Output bits read high, so any output bit in a NOR group holds that source at zero
    p2_eff = p2_s | port2_is_output;
    src_sel = wake_ff[`SRWD_SRC_LO +: 3];
    case (src_sel)
      3'h1: src_lvl = p3_s[0];
      3'h2: src_lvl = p3_s[1];
      3'h3: src_lvl = p3_s[2];
      3'h4: src_lvl = p3_s[3];
      3'h5: src_lvl = p2_eff[7];
      3'h6: src_lvl = ~|p2_eff[3:0];
      3'h7: src_lvl = ~|p2_eff;
      default: src_lvl = 1'b0;
    endcase
    // Code zero never wakes; only reset leaves stop then
    wake_hit = (src_sel != 3'h0) &&
      (src_lvl == wake_ff[`SRWD_POL_BIT]);
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic acc, wr, hit;
  logic tick_x, tick_r, tick, wd_tick, wd_to, stop_wake;
  always_comb begin
    acc = psel && penable && !pready_ff;
    wr = acc && pwrite;
    hit = (paddr == `SRWD_ADDR_WAKE) || (paddr == `SRWD_ADDR_WDM) ||
      (paddr == `SRWD_ADDR_CTRL) || (paddr == `SRWD_ADDR_STAT);
    tick_x = tk_s[1] && !tk_d_ff[1];
    tick_r = tk_s[0] && !tk_d_ff[0];
    tick = wdm_ff[`SRWD_CSRC_BIT] ? tick_x : tick_r;
    // Crystal halts in stop so only RC may advance then
    wd_tick = tick && (mode_ff == srwd_pkg::SRWD_RUN ||
      (mode_ff == srwd_pkg::SRWD_HALT && wdm_ff[`SRWD_HALT_BIT]) ||
      (mode_ff == srwd_pkg::SRWD_STOP && wdm_ff[`SRWD_STOP_BIT] &&
       !wdm_ff[`SRWD_CSRC_BIT]));
    wd_to = wd_on_ff && wd_tick &&
      (wd_ff + 32'h1 >= tap_len(wdm_ff[1:0], wdm_ff[`SRWD_CSRC_BIT]));
    stop_wake = (mode_ff == srwd_pkg::SRWD_STOP) && wake_hit;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_wake = wake_ff;
    nxt_wdm = wdm_ff;
    nxt_warm = warm_ff;
    nxt_win = win_ff;
    nxt_por = (por_ff != 32'h0) ? por_ff - 32'h1 : 32'h0;
    nxt_wd = wd_ff;
    nxt_wd_on = wd_on_ff;
    nxt_mode = mode_ff;
    nxt_prdata = 32'h0;
    nxt_pready = acc;
    nxt_pslverr = acc && !hit;
    nxt_wrst = 1'b0;
    nxt_flag = 3'h0;
    // Write window counts processor cycles from each restart
    if (win_ff != 7'(`SRWD_WIN_CYC) && por_ff == 32'h0) begin
      nxt_win = win_ff + 7'h1;
    end
    if (wr && paddr == `SRWD_ADDR_WAKE) begin
      nxt_wake = pwdata[7:0] & `SRWD_WAKE_MASK;
    end
    if (wr && paddr == `SRWD_ADDR_WDM &&
        win_ff != 7'(`SRWD_WIN_CYC)) begin
      nxt_wdm = pwdata[7:0] & `SRWD_WDM_MASK;
    end
    if (acc && !pwrite && paddr == `SRWD_ADDR_WAKE) begin
      nxt_prdata = {24'h0, warm_ff, 7'h0};
    end
    if (acc && !pwrite && paddr == `SRWD_ADDR_STAT) begin
      nxt_prdata = {16'h0, 1'b0, win_ff, 4'h0, mode_ff, wd_on_ff,
        grst_ff};
    end
    // Watchdog mode register reads zero
    if (wd_on_ff && wd_tick) begin
      nxt_wd = wd_ff + 32'h1;
    end
    case (mode_ff)
      srwd_pkg::SRWD_RUN: begin
        if (stop_cmd) begin
          nxt_mode = srwd_pkg::SRWD_STOP;
          nxt_warm = 1'b1;
        end else if (halt_cmd) begin
          nxt_mode = srwd_pkg::SRWD_HALT;
        end
      end
      srwd_pkg::SRWD_HALT: begin
        if (refresh_cmd || stop_cmd) begin
          nxt_mode = srwd_pkg::SRWD_RUN;
        end
      end
      srwd_pkg::SRWD_STOP: begin
        if (stop_wake) begin
          nxt_mode = srwd_pkg::SRWD_RUN;
          nxt_wrst = 1'b1;
          nxt_win = 7'h0;
          if (!wake_ff[`SRWD_DLY_BIT]) begin
            nxt_por = 32'(POR_CYC);
          end
        end
      end
      default: nxt_mode = srwd_pkg::SRWD_RUN;
    endcase
    if (refresh_cmd) begin
      nxt_wd_on = 1'b1;
      nxt_wd = 32'h0;
      nxt_flag = 3'h7;
    end
    if (wd_to) begin
      nxt_wd_on = 1'b0;
      nxt_wd = 32'h0;
      nxt_warm = 1'b0;
      nxt_por = 32'(POR_CYC);
      nxt_win = 7'h0;
      nxt_mode = srwd_pkg::SRWD_RUN;
      nxt_wdm = `SRWD_WDM_RST;
      nxt_wrst = 1'b1;
    end
    nxt_grst = (nxt_por != 32'h0) || lv_s;
    if (lv_s) begin
      nxt_por = 32'(POR_CYC);
      nxt_warm = 1'b0;
      nxt_wake = `SRWD_WAKE_RST;
      nxt_wdm = `SRWD_WDM_RST;
      nxt_wd_on = 1'b0;
      nxt_wd = 32'h0;
      nxt_win = 7'h0;
      nxt_mode = srwd_pkg::SRWD_RUN;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Power-up counts as a trip: the delay runs from reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ff <= `SRWD_WAKE_RST;
      wdm_ff <= `SRWD_WDM_RST;
      warm_ff <= 1'b0;
      win_ff <= 7'h0;
      por_ff <= 32'(POR_CYC);
      wd_ff <= 32'h0;
      wd_on_ff <= 1'b0;
      mode_ff <= srwd_pkg::SRWD_RUN;
      tk_d_ff <= 2'h0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      grst_ff <= 1'b1;
      wrst_ff <= 1'b0;
      flag_ff <= 3'h0;
    end else begin
      wake_ff <= nxt_wake;
      wdm_ff <= nxt_wdm;
      warm_ff <= nxt_warm;
      win_ff <= nxt_win;
      por_ff <= nxt_por;
      wd_ff <= nxt_wd;
      wd_on_ff <= nxt_wd_on;
      mode_ff <= nxt_mode;
      tk_d_ff <= tk_s;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      grst_ff <= nxt_grst;
      wrst_ff <= nxt_wrst;
      flag_ff <= nxt_flag;
    end
  end

  // Restart vector is a fixed constant, loaded each cycle into a register without reset
  logic [15:0] rst_addr_ff;
  always_ff @(posedge clk) begin
    rst_addr_ff <= `SRWD_RESTART;
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign global_reset = grst_ff;
  assign wake_restart = wrst_ff;
  assign restart_addr = rst_addr_ff;
  assign flag_update = flag_ff;
  assign wd_running = wd_on_ff;
endmodule

// ===== testbench/srwd_top_checker.sv
// Concurrent checks on the ports of the recovery and watchdog block
`timescale 1ns/1ns
module srwd_top_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_voltage_trip_level,
  input wire logic refresh_cmd,
  input wire logic global_reset,
  input wire logic wake_restart,
  input wire logic [15:0] restart_addr,
  input wire logic [2:0] flag_update
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Slave answers one cycle after the first access edge
  chk_ready_pulse: assert property (
    psel && penable && !pready |=> pready) else $error("ready missing");
  chk_wdm_write_only: assert property (
    pready && !pwrite && paddr == 12'h03C |-> prdata == 32'h0)
    else $error("mode register readable");
  chk_wake_reads: assert property (
    pready && !pwrite && paddr == 12'h02C |-> prdata[6:0] == 7'h00)
    else $error("write-only wake bits readable");
  chk_unmapped_err: assert property (
    pready && !(paddr inside {12'h02C, 12'h03C, 12'h040, 12'h044})
    |-> pslverr) else $error("unmapped access not refused");
  // Three-flop filter plus agreement stage, then the registered output
  chk_low_supply: assert property (
    low_voltage_trip_level [*5] |=> global_reset)
    else $error("low supply without reset");
  chk_restart_addr: assert property (
    wake_restart |-> restart_addr == 16'h000C)
    else $error("bad restart address");
  chk_flag_strobe: assert property (
    refresh_cmd && !global_reset |=> flag_update == 3'h7)
    else $error("flags not strobed on refresh");
  chk_flag_cause: assert property (
    flag_update != 3'h0 |-> $past(refresh_cmd))
    else $error("flags strobed without refresh");
  chk_power_delay: assert property (
    $fell(rst) |-> global_reset [*8]) else $error("power delay short");
  cov_wake: cover property (wake_restart);
  cov_refresh: cover property (refresh_cmd);
  cov_refused: cover property (pready && pslverr);
endmodule
bind srwd_top srwd_top_checker u_chk (.*);

// ===== testbench/srwd_core_model.sv
// Processor core model issuing refresh and stop instructions
`timescale 1ns/1ns
module srwd_core_model (
  input wire logic clk,
  input wire logic global_reset,
  input wire logic keep_alive,
  input wire logic req_stop,
  output logic refresh_cmd,
  output logic stop_cmd
);
  logic [3:0] gap_ff;
  // ****
  // Instruction issue
  // ****
  // A core held in reset issues nothing; refresh every 16 cycles
  always_ff @(posedge clk) begin
    gap_ff <= keep_alive ? gap_ff + 4'h1 : 4'h0;
    refresh_cmd <= keep_alive && !global_reset && gap_ff == 4'h0;
    stop_cmd <= req_stop && !global_reset;
  end
endmodule

// ===== testbench/tb_stop_recovery_and_watchdog_ctrl.sv
// Self-checking bench for the recovery and watchdog block
`timescale 1ns/1ns
module tb_stop_recovery_and_watchdog_ctrl;
  localparam int POR = 20;
  localparam int RCMS = 2;
  logic clk, pready, pslverr, global_reset, wake_restart;
  logic refresh_cmd, stop_cmd, rerr;
  logic rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic keep_alive = 1'b0, req_stop = 1'b0, rc_clock_tick = 1'b0;
  logic low_voltage_trip_level = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] port3_in = 4'h0;
  logic [7:0] port2_in = 8'h00, rnd = 8'h58;
  logic [1:0] phase = 2'h0;
  int n_errors = 0, checks_done = 0, ticks = 0, gr_cnt = 0, wr_cnt = 0;
  int n, base_g, base_w;
  srwd_top #(.POR_CYC(POR), .RC_MS_CYC(RCMS)) dut (.halt_cmd(1'b0),
    .crystal_clock_tick(1'b0), .port2_is_output(8'h00),
    .restart_addr(), .flag_update(), .wd_running(), .*);
  srwd_core_model core (.clk(clk), .global_reset(global_reset),
    .keep_alive(keep_alive), .req_stop(req_stop),
    .refresh_cmd(refresh_cmd), .stop_cmd(stop_cmd));
  // ****
  // Clocks, counters and helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Slow RC ticks, counted from the latest refresh
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    rc_clock_tick <= phase[1];
    ticks <= refresh_cmd ? 0 : ticks + (phase == 2'h2);
    gr_cnt <= gr_cnt + global_reset;
    wr_cnt <= wr_cnt + wake_restart;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int tap_ticks(input logic [1:0] c);
    return (c == 2'h0 ? 5 : c == 2'h1 ? 15 : c == 2'h2 ? 25 : 100) * RCMS;
  endfunction
  // Pin levels {port3, port2}; even codes use low polarity, so invert
  function automatic logic [11:0] wake_pins(input logic [2:0] c,
    input logic act, input logic [3:0] hi);
    logic [11:0] p;
    case (c)
      3'h5: p = 12'h080;
      3'h6: p = {4'h0, hi, 4'h0};
      3'h7: p = 12'h000;
      default: p = {4'h1 << (c - 3'h1), 8'h00};
    endcase
    if (!act) p = (c > 3'h5) ? 12'h0FF : 12'h000;
    return c[0] ? p : ~p;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look between edges so the answer is read where it is settled
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_gr(input logic lvl);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (global_reset !== lvl && k < 3000);
    if (k >= 3000) n_errors++;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hang far beyond the expected run length counts as a failure
  initial begin
    #(40 * 40000);
    n_errors++;
    print_verdict;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (global_reset !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    check(n >= POR && n <= POR + 4, 1'b1);
    apb(1'b0, 12'h02C, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 12'h03C, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    check(rerr, 1'b1);
    // Random tap and reserved bits written inside the open window
    rnd = lfsr(rnd);
    apb(1'b1, 12'h03C, {24'h0, rnd[7:5], 3'h3, rnd[1:0]});
    keep_alive <= 1'b1;
    base_g = gr_cnt;
    repeat (300) @(posedge clk);
    check(gr_cnt - base_g, 0);
    apb(1'b0, 12'h044, 32'h0);
    check(rdat[1], 1'b1);
    keep_alive <= 1'b0;
    base_w = wr_cnt;
    wait_gr(1'b1);
    n = tap_ticks(rnd[1:0]);
    check(ticks + 1 >= n && ticks <= n + 3, 1'b1);
    repeat (2) @(posedge clk);
    check(wr_cnt - base_w, 1);
    // Late write must be ignored, so the default tap stays
    wait_gr(1'b0);
    repeat (80) @(posedge clk);
    apb(1'b1, 12'h03C, 32'h0000000F);
    keep_alive <= 1'b1;
    @(posedge clk);
    keep_alive <= 1'b0;
    wait_gr(1'b1);
    n = tap_ticks(2'h1);
    check(ticks + 1 >= n && ticks <= n + 3, 1'b1);
    wait_gr(1'b0);
    // Every wake source; only the last keeps the reset delay
    for (int c = 1; c < 8; c++) begin
      rnd = lfsr(rnd);
      {port3_in, port2_in} <= wake_pins(c[2:0], 1'b0, rnd[3:0]);
      apb(1'b1, 12'h02C, {24'h0, 1'b0, c[0], c != 7, c[2:0], 2'h0});
      req_stop <= 1'b1;
      @(posedge clk);
      req_stop <= 1'b0;
      apb(1'b0, 12'h02C, 32'h0);
      check(rdat, 32'h80);
      base_w = wr_cnt;
      base_g = gr_cnt;
      {port3_in, port2_in} <= wake_pins(c[2:0], 1'b1, rnd[3:0]);
      repeat (10) @(posedge clk);
      {port3_in, port2_in} <= wake_pins(c[2:0], 1'b0, rnd[3:0]);
      repeat (3) @(posedge clk);
      check(wr_cnt - base_w, 1);
      check(gr_cnt != base_g, c == 7);
      wait_gr(1'b0);
    end
    low_voltage_trip_level <= 1'b1;
    repeat (7) @(posedge clk);
    check(global_reset, 1'b1);
    low_voltage_trip_level <= 1'b0;
    wait_gr(1'b0);
    apb(1'b0, 12'h02C, 32'h0);
    check(rdat, 32'h0);
    print_verdict;
  end
endmodule
